// File: pkg/mrp_pkg.sv
// mrp_pkg: constants and types for the mode register read path
// assumes one 200 MHz command clock; command/address pins already split into
// rising and falling halves by the input stage
package mrp_pkg;

	// ==========================================================
	// command encoding
	localparam int          CA_W        = 10;
	localparam logic [3:0]  CMD_MRR     = 4'h8;   // ca3 high, ca2..ca0 low
	localparam int          MRR_PERIOD  = 2;      // command period in cycles
	localparam int          BURST_LEN   = 4;

	// ==========================================================
	// mode register addresses
	localparam logic [7:0]  MA_TEMP     = 8'h04;
	localparam logic [7:0]  MA_CAL_A    = 8'h20;
	localparam logic [7:0]  MA_CAL_B    = 8'h28;

	// ==========================================================
	// calibration patterns, bit n is bit time n
	localparam logic [3:0]  PAT_A       = 4'h5;   // 1,0,1,0
	localparam logic [3:0]  PAT_B       = 4'hc;   // 0,0,1,1

	// ==========================================================
	// temperature status
	localparam int          TEMP_LSB    = 0;
	localparam int          TEMP_W      = 3;
	localparam logic [2:0]  TEMP_HOT    = 3'h3;   // case may be above 85 C
	localparam logic [7:0]  MR4_RST     = 8'h00;

	// ==========================================================
	// timing
	localparam int          CLK_KHZ     = 200000;
	localparam int          TSI_MS      = 32;
	localparam int          TSI_CYCLES  = TSI_MS * CLK_KHZ;   // longest time, exact

	// ==========================================================
	// types
	typedef struct packed {
		logic            cke;
		logic            cs_n;
		logic [CA_W-1:0] ca_r;
		logic [CA_W-1:0] ca_f;
	} mrp_ca_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WAIT  = 2'b01,
		ST_BURST = 2'b10
	} mrp_state_t;

endpackage : mrp_pkg

// File: rtl/mrp_read_path.sv
// mrp_read_path: device side mode register read decode and four-beat burst
// assumes the controller keeps its own spacing rules; pins arrive unsynchronised
//
// Functional notes
// [R1] read command is cs low, ca3..ca0 = 1000 on the rising edge
// [R2] register address is rising ca9..ca4 over falling ca1..ca0
// [R3] register data on low byte, first beat, read latency after command
// [R4] later beats undefined except calibration reads, which carry the pattern
// [R5] upper byte lanes carry valid levels for the whole burst
// [R6] every strobe toggles throughout the register read burst
// [R7] burst is always four beats and is never interrupted
// [R8] command period is two cycles, controller sends only no-ops meanwhile
// [R9] controller spaces a following write by the read-to-write formula
// [R10] controller spaces a following register write by rl plus strobe plus three
// [R11] controller never truncates a read or write burst with a register read
// [R12] after a read, register read waits half the burst length
// [R13] after a write, register read waits wl plus one plus bl/2 plus turnaround
// [R14] truncated bursts use their shortened length in the spacing
// [R15] temperature register refreshed at least every 32 ms, readable normally
// [R16] temperature status fresh on leaving self refresh or power-down
// [R17] controller picks its poll period to stay inside the 2 C headroom
// [R18] temperature field is three bits, code 011 means possibly above 85 C
// [R19] address 32 returns pattern 1,0,1,0
// [R20] address 40 returns pattern 0,0,1,1
// [R21] calibration pattern on bit zero of each lane, replicated across the lane
// [R22] controller issues calibration reads only in the idle state
// [R23] read accepted with banks idle or active, bank state left unchanged
// [R24] undefined beats and upper lanes of non-calibration reads are driven as zero
module mrp_read_path
	import mrp_pkg::*;
#(
	parameter int DQ_W      = 16,
	parameter int RL        = 3,
	parameter int DQSCK_CYC = 1,
	parameter int TSI_CYC   = TSI_CYCLES
) (
	input  wire logic              mclk,
	input  wire logic              srst,
	input  wire mrp_ca_t           ca_pins,
	input  wire logic [TEMP_W-1:0] temp_code,
	output logic [7:0]             mr_sel_addr,
	input  wire logic [7:0]        mr_sel_data,
	output logic [DQ_W-1:0]        dq_out,
	output logic                   dq_oe,
	output logic [DQ_W/8-1:0]      dqs_out,
	output logic                   dqs_oe,
	output logic                   mrr_busy
);

	localparam int NLANES = DQ_W / 8;
	localparam int LAT    = RL + DQSCK_CYC;
	localparam int LAT_A  = LAT;

	// ==========================================================
	// parameter checks
	generate
		if (DQ_W < 8 || DQ_W % 8 != 0) begin : g_bad_width
			$error("DQ_W must be a multiple of 8");
		end
		if (LAT < 2 || LAT > 255) begin : g_bad_lat
			$error("RL + DQSCK_CYC must lie in 2..255");
		end
		if (TSI_CYC < 2) begin : g_bad_tsi
			$error("TSI_CYC must be at least 2");
		end
	endgenerate

	// ==========================================================
	// pin synchronisers
	mrp_ca_t           ca_meta_reg;
	mrp_ca_t           ca_sync_reg;
	logic [TEMP_W-1:0] temp_meta_reg;
	logic [TEMP_W-1:0] temp_sync_reg;
	logic              cke_prev_reg;

	always_ff @(posedge mclk) begin
		if (srst) begin
			// idle pin levels, so no false cke rise follows reset
			ca_meta_reg   <= '{cke: 1'b1, cs_n: 1'b1, ca_r: '0, ca_f: '0};
			ca_sync_reg   <= '{cke: 1'b1, cs_n: 1'b1, ca_r: '0, ca_f: '0};
			temp_meta_reg <= '0;
			temp_sync_reg <= '0;
			cke_prev_reg  <= 1'b1;
		end else begin
			ca_meta_reg   <= ca_pins;
			ca_sync_reg   <= ca_meta_reg;
			temp_meta_reg <= temp_code;
			temp_sync_reg <= temp_meta_reg;
			cke_prev_reg  <= ca_sync_reg.cke;
		end
	end

	// ==========================================================
	// command decode
	mrp_state_t state_reg;
	logic       mrr_hit;
	logic [7:0] cmd_addr;

	// no bank state is touched, so reads work with banks idle or active
	assign mrr_hit  = (state_reg == ST_IDLE) && ca_sync_reg.cke && !ca_sync_reg.cs_n
		&& (ca_sync_reg.ca_r[3:0] == CMD_MRR);   // [R1] [R23]
	assign cmd_addr = {ca_sync_reg.ca_r[9:4], ca_sync_reg.ca_f[1:0]};   // [R2]

	// ==========================================================
	// sequencer
	logic [7:0] lat_cnt_reg;
	logic [1:0] beat_reg;
	logic [7:0] addr_reg;

	// commands seen while busy are ignored: the burst cannot be cut short
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg   <= ST_IDLE;
			lat_cnt_reg <= 8'h00;
			beat_reg    <= 2'h0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (mrr_hit) begin
						state_reg   <= ST_WAIT;
						lat_cnt_reg <= 8'(LAT - 1);   // [R3]
					end
				end
				ST_WAIT: begin
					if (lat_cnt_reg == 8'h01) begin
						state_reg <= ST_BURST;
						beat_reg  <= 2'h0;
					end else begin
						lat_cnt_reg <= lat_cnt_reg - 8'h01;
					end
				end
				ST_BURST: begin
					beat_reg <= beat_reg + 2'h1;
					if (beat_reg == 2'(BURST_LEN - 1)) begin   // [R7]
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			addr_reg <= 8'h00;
		end else if (mrr_hit) begin
			addr_reg <= cmd_addr;   // [R2]
		end
	end

	assign mr_sel_addr = addr_reg;
	assign mrr_busy    = (state_reg != ST_IDLE);

	// ==========================================================
	// temperature status register
	logic [31:0] tsi_cnt_reg;
	logic [7:0]  mr4_reg;
	logic        tsi_due;
	logic        lp_exit;

	assign tsi_due = (tsi_cnt_reg == 32'h0);
	// cke rising marks leaving self refresh or power-down
	assign lp_exit = ca_sync_reg.cke && !cke_prev_reg;   // [R16]

	always_ff @(posedge mclk) begin
		if (srst) begin
			tsi_cnt_reg <= 32'h0;
		end else if (tsi_due || lp_exit) begin
			tsi_cnt_reg <= 32'(TSI_CYC - 1);   // [R15]
		end else begin
			tsi_cnt_reg <= tsi_cnt_reg - 32'h1;
		end
	end

	// first sample lands right after reset since the counter starts at zero
	always_ff @(posedge mclk) begin
		if (srst) begin
			mr4_reg <= MR4_RST;
		end else if (tsi_due || lp_exit) begin
			mr4_reg[TEMP_LSB +: TEMP_W] <= temp_sync_reg;   // [R15] [R18]
		end
	end

	// ==========================================================
	// beat data
	logic       cal_a;
	logic       cal_b;
	logic       burst_next;
	logic [1:0] beat_next;
	logic [7:0] low_byte;
	logic       pat_bit;

	assign cal_a      = (addr_reg == MA_CAL_A);
	assign cal_b      = (addr_reg == MA_CAL_B);
	assign burst_next = ((state_reg == ST_WAIT) && (lat_cnt_reg == 8'h01))
		|| ((state_reg == ST_BURST) && (beat_reg != 2'(BURST_LEN - 1)));
	assign beat_next  = (state_reg == ST_WAIT) ? 2'h0 : beat_reg + 2'h1;
	assign low_byte   = (addr_reg == MA_TEMP) ? mr4_reg : mr_sel_data;   // [R15]
	assign pat_bit    = cal_a ? PAT_A[beat_next] : PAT_B[beat_next];   // [R19] [R20]

	logic [DQ_W-1:0] dq_next;

	generate
		for (genvar l = 0; l < NLANES; l++) begin : g_lane
			always_comb begin
				if (cal_a || cal_b) begin
					dq_next[8*l +: 8] = {8{pat_bit}};   // [R21] [R4]
				end else if (l == 0 && beat_next == 2'h0) begin
					dq_next[8*l +: 8] = low_byte;   // [R3]
				end else begin
					dq_next[8*l +: 8] = 8'h00;   // [R5] [R24]
				end
			end
		end
	endgenerate

	// ==========================================================
	// output drivers
	logic [DQ_W-1:0] dq_reg;
	logic            oe_reg;
	logic            dqs_reg;

	always_ff @(posedge mclk) begin
		if (srst) begin
			dq_reg  <= '0;
			oe_reg  <= 1'b0;
			dqs_reg <= 1'b0;
		end else begin
			oe_reg <= burst_next;
			if (burst_next) begin
				dq_reg  <= dq_next;
				dqs_reg <= (state_reg == ST_BURST) ? !dqs_reg : 1'b1;   // [R6]
			end else begin
				dq_reg  <= '0;
				dqs_reg <= 1'b0;
			end
		end
	end

	assign dq_out  = dq_reg;
	assign dq_oe   = oe_reg;
	assign dqs_out = {NLANES{dqs_reg}};   // [R6]
	assign dqs_oe  = oe_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	sequence s_burst4;
		oe_reg [*4] ##1 !oe_reg;
	endsequence

	sequence s_cmd_seen;
		mrr_hit;
	endsequence

	a_cmd_decode: assert property (   // [R1]
		(ca_sync_reg.cke && !ca_sync_reg.cs_n && ca_sync_reg.ca_r[3:0] == 4'h8
			&& state_reg == ST_IDLE) |=> state_reg == ST_WAIT)
		else $error("read command not decoded");

	a_addr_capture: assert property (   // [R2]
		s_cmd_seen |=> addr_reg == {$past(ca_sync_reg.ca_r[9:4]), $past(ca_sync_reg.ca_f[1:0])})
		else $error("register address wrong");

	a_first_beat: assert property (   // [R3]
		s_cmd_seen |-> !oe_reg [*1] ##(LAT_A) oe_reg)
		else $error("first beat not at read latency");

	a_burst_four: assert property (   // [R7]
		$rose(oe_reg) |-> s_burst4)
		else $error("burst is not four beats");

	a_dqs_toggle: assert property (   // [R6]
		oe_reg && $past(oe_reg) |-> dqs_reg != $past(dqs_reg))
		else $error("strobe did not toggle");

	a_cal_pat_a: assert property (   // [R19]
		oe_reg && cal_a |-> dq_out == {DQ_W{PAT_A[beat_reg]}})
		else $error("pattern a wrong");

	a_cal_pat_b: assert property (   // [R20]
		oe_reg && cal_b |-> dq_out == {DQ_W{PAT_B[beat_reg]}})
		else $error("pattern b wrong");

	a_upper_lane_zero: assert property (   // [R24] [R5]
		oe_reg && !cal_a && !cal_b && beat_reg == 2'h0 |->
			dq_out[7:0] == ((addr_reg == MA_TEMP) ? $past(mr4_reg) : $past(mr_sel_data))
			&& (dq_out >> 8) == '0
			##1 dq_out == '0)
		else $error("normal read data wrong");

	a_temp_update: assert property (   // [R15]
		tsi_due |=> mr4_reg[2:0] == $past(temp_sync_reg))
		else $error("temperature status not refreshed");

	// age since the last status load, kept apart from the interval counter
	logic [31:0] tsi_age_reg;

	always_ff @(posedge mclk) begin
		if (srst || tsi_due || lp_exit) begin
			tsi_age_reg <= 32'h0;
		end else begin
			tsi_age_reg <= tsi_age_reg + 32'h1;
		end
	end

	a_tsi_bound: assert property (   // [R15]
		tsi_age_reg < 32'(TSI_CYC))
		else $error("refresh interval too long");

	a_lp_refresh: assert property (   // [R16]
		lp_exit |=> mr4_reg[2:0] == $past(temp_sync_reg) && tsi_cnt_reg == 32'(TSI_CYC - 1))
		else $error("status stale after low power exit");

endmodule : mrp_read_path

// File: test/mrp_ctrl_model.sv
// mrp_ctrl_model: controller side of the command/address pins
// assumes the bench calls mrr() just after a rising edge
module mrp_ctrl_model
	import mrp_pkg::*;
(
	input  wire logic mclk,
	output mrp_ca_t   ca_pins
);
	timeunit 1ns;
	timeprecision 100ps;

	int         cmd_seq = 0;
	int         cmd_done;
	logic [7:0] cmd_addr;
	logic       cke_lvl = 1'b1;

	// ==========================================================
	// pin driver
	// only register reads issued, mid burst too if the bench calls mrr() then
	initial begin
		ca_pins  = '{cke: 1'b1, cs_n: 1'b1, ca_r: '0, ca_f: '0};
		cmd_done = 0;
		forever begin
			@(posedge mclk);
			#1;
			if (cmd_seq != cmd_done) begin
				ca_pins  = '{cke: cke_lvl, cs_n: 1'b0,
					ca_r: {cmd_addr[7:2], CMD_MRR},
					ca_f: {8'h00, cmd_addr[1:0]}};
				cmd_done = cmd_seq;
			end else begin
				// deselect, ca lines keep moving so stale bits never look valid
				ca_pins = '{cke: cke_lvl, cs_n: 1'b1,
					ca_r: ~ca_pins.ca_r, ca_f: ~ca_pins.ca_f};
			end
		end
	end

	task mrr(input logic [7:0] a);
		cmd_addr = a;
		cmd_seq++;
	endtask : mrr
endmodule : mrp_ctrl_model

// File: test/mrp_read_path_tb.sv
// mrp_read_path_tb: self-checking bench for the register read path
// assumes mrp_ctrl_model on the pins and a fake register file on mr_sel_data
module mrp_read_path_tb
	import mrp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int DQW = 16;
	localparam int TSI = 50;
	typedef struct packed {
		logic [7:0]       addr;
		logic [0:3][15:0] beat;
	} mrp_row_t;

	logic           mclk;
	logic           srst;
	mrp_ca_t        ca_pins;
	logic [2:0]     temp_code;
	logic [7:0]     mr_sel_addr;
	logic [7:0]     mr_sel_data;
	logic [DQW-1:0] dq_out;
	logic           dq_oe;
	logic [1:0]     dqs_out;
	logic           dqs_oe;
	logic           mrr_busy;
	int             err_count;
	int             tests_run;
	mrp_row_t       rows [7];

	// ==========================================================
	// structure
	mrp_read_path #(.DQ_W(DQW), .TSI_CYC(TSI)) uut (.mclk(mclk), .srst(srst),
		.ca_pins(ca_pins), .temp_code(temp_code), .mr_sel_addr(mr_sel_addr),
		.mr_sel_data(mr_sel_data), .dq_out(dq_out), .dq_oe(dq_oe),
		.dqs_out(dqs_out), .dqs_oe(dqs_oe), .mrr_busy(mrr_busy));
	mrp_ctrl_model ctrl (.mclk(mclk), .ca_pins(ca_pins));
	assign mr_sel_data = mr_sel_addr ^ 8'ha5;

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// ==========================================================
	// helpers
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask : tick

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask : chk

	task check_beats(input logic [0:3][15:0] b);
		chk("busy", 32'h1, 32'(mrr_busy));
		for (int n = 0; n < 4; n++) begin
			tick(1);
			chk("dq_oe", 32'h1, 32'(dq_oe));
			chk("dqs_oe", 32'h1, 32'(dqs_oe));
			chk("dq", 32'(b[n]), 32'(dq_out));
			chk("dqs", 32'({2{~n[0]}}), 32'(dqs_out));
		end
		tick(1);
		chk("dq_oe end", 32'h0, 32'(dq_oe));
		chk("dq idle", 32'h0, 32'(dq_out));
		chk("busy end", 32'h0, 32'(mrr_busy));
	endtask : check_beats

	task run_read(input logic [7:0] a, input logic [0:3][15:0] b);
		ctrl.mrr(a);
		// pins after the next edge, two sync flops, decode, three wait cycles
		tick(6);
		chk("dq_oe early", 32'h0, 32'(dq_oe));
		chk("addr", 32'(a), 32'(mr_sel_addr));
		check_beats(b);
	endtask : run_read

	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	// ==========================================================
	// tests
	initial begin
		srst = 1'b1;
		temp_code = TEMP_HOT;
		err_count = 0;
		tests_run = 0;
		rows = '{'{8'h20, {16'hffff, 16'h0000, 16'hffff, 16'h0000}},
			'{8'h28, {16'h0000, 16'h0000, 16'hffff, 16'hffff}},
			'{8'h04, {16'h0003, 48'h0}}, '{8'h01, {16'h00a4, 48'h0}},
			'{8'hff, {16'h005a, 48'h0}}, '{8'h21, {16'h0084, 48'h0}},
			'{8'h29, {16'h008c, 48'h0}}};
		tick(1);
		chk("rst dq_oe", 32'h0, 32'(dq_oe));
		chk("rst busy", 32'h0, 32'(mrr_busy));
		tick(1);
		srst = 1'b0;
		// one full sensor interval so the hot code is in place
		tick(TSI + 10);
		foreach (rows[i]) run_read(rows[i].addr, rows[i].beat);
		// second command decodes during the data burst and must be dropped
		ctrl.mrr(MA_CAL_A);
		tick(5);
		ctrl.mrr(8'h01);
		tick(1);
		check_beats(rows[0].beat);
		repeat (10) begin
			tick(1);
			chk("no extra burst", 32'h0, 32'(dq_oe));
		end
		temp_code = 3'h6;
		tick(TSI + 10);
		run_read(MA_TEMP, {16'h0006, 48'h0});
		ctrl.cke_lvl = 1'b0;
		temp_code = 3'h1;
		tick(3);
		ctrl.cke_lvl = 1'b1;
		tick(6);
		run_read(MA_TEMP, {16'h0001, 48'h0});
		// reset in mid burst, then a clean read
		ctrl.mrr(8'h01);
		tick(9);
		srst = 1'b1;
		tick(1);
		chk("abort dq_oe", 32'h0, 32'(dq_oe));
		chk("abort addr", 32'h0, 32'(mr_sel_addr));
		tick(1);
		srst = 1'b0;
		tick(2);
		run_read(8'h01, {16'h00a4, 48'h0});
		print_verdict;
	end

	// run needs about 275 cycles
	initial begin
		#20000;
		err_count++;
		print_verdict;
	end
endmodule : mrp_read_path_tb
